/* File: rtl/scpsel_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - PLL runs per the enable bit; enable resets to 1.
// - Locked PLL gives fixed 48MHz USB clock regardless of system select.
// - Fast clock is oscillator unless enabled, locked and select is 100, 101 or 110; 6/12/16MHz.
// - Input select bit: 0 means 12MHz reference, 1 means 6MHz.
// - Crystal 12MHz reference halved then times 8; 6MHz times 8.
// - Choosing internal 12MHz RC forces input select bit to 0.
// - Disabling PLL clears stable flag; set only after lock.
// - Bit 6 of PLL control always reads 0.
// - Fast source select picks crystal or internal 12MHz RC.
// - Slow source select picks 32.768kHz crystal or 32kHz RC.
// - System clock select chooses fast or slow source and divide ratio.
// - Exactly one fast and one slow source always selected.
// - Oscillator clocks also feed watchdog and time base.
// - Internal fast RC is fixed 12MHz, needs no pins.
// - Internal RC chosen releases both fast crystal pins to GPIO.
// - Fast system clock divided by 1 to 64 per system select.
// Clocks are modelled as one-cycle enables on pclk, one per oscillator edge.
module scpsel_top #(
    parameter int LOCK_CYCLES = scpsel_pkg::LOCK_REF_CYCLES,
    parameter int LOCK_WIDTH  = 12
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_fast_crystal_osc,
    input  wire logic        int_fast_rc_osc,
    input  wire logic        ext_slow_crystal_osc,
    input  wire logic        int_slow_rc_osc,
    input  wire logic        pll_ref_6mhz_en,
    input  wire logic        pll_vco_96mhz_en,
    output logic             pll_power_on,
    output logic             usb_clk_en,
    output logic             fast_osc_clock,
    output logic             fast_clock,
    output logic             slow_sub_clock,
    output logic             sys_clk_en,
    output logic             wdt_clk_en,
    output logic             timebase_clk_en,
    output logic             osc_pins_gpio
);
    initial begin
        if (LOCK_WIDTH < 2) begin
            $error("scpsel_top LOCK_WIDTH too small");
        end
        if (LOCK_CYCLES < 1 || LOCK_CYCLES >= (1 << LOCK_WIDTH)) begin
            $error("scpsel_top LOCK_CYCLES does not fit LOCK_WIDTH");
        end
    end

    logic [7:0] pll_control_reg;
    logic [7:0] system_clock_control_reg;
    logic [7:0] pll_control_next;
    logic       pll_enable_bit;
    logic       pll_stable_flag;
    logic       pll_input_select;
    logic [2:0] pll_output_select;
    logic       fast_source_select;
    logic       slow_source_select;
    logic [2:0] system_clock_select;
    logic       wr_pll;
    logic       wr_scc;
    logic       access;
    logic [31:0] rdata_next;
    logic       addr_ok;
    logic       fast_on_pll;

    scpsel_pkg::scpsel_pll_state_t pll_state_reg;
    logic [LOCK_WIDTH-1:0] lock_cnt_reg;

    assign access  = psel && penable;
    assign addr_ok = (paddr == scpsel_pkg::PLL_CONTROL_ADDR)
                  || (paddr == scpsel_pkg::SYS_CLOCK_CTRL_ADDR)
                  || (paddr == scpsel_pkg::CLOCK_STATUS_ADDR);
    assign pready  = 1'b1;
    assign pslverr = access && !addr_ok;
    assign wr_pll  = access && pwrite && pstrb[0] && (paddr == scpsel_pkg::PLL_CONTROL_ADDR);
    assign wr_scc  = access && pwrite && pstrb[0] && (paddr == scpsel_pkg::SYS_CLOCK_CTRL_ADDR);

    assign pll_enable_bit      = pll_control_reg[scpsel_pkg::PLL_CONTROL_ENABLE_BIT];
    assign pll_input_select    = pll_control_reg[scpsel_pkg::PLL_CONTROL_INSEL_BIT];
    assign pll_output_select   = pll_control_reg[scpsel_pkg::PLL_CONTROL_OSEL_LO +: 3];
    assign fast_source_select  = system_clock_control_reg[scpsel_pkg::SCC_FAST_SEL_BIT];
    assign slow_source_select  = system_clock_control_reg[scpsel_pkg::SCC_SLOW_SEL_BIT];
    assign system_clock_select = system_clock_control_reg[scpsel_pkg::SCC_CKS_LO +: 3];
    assign pll_stable_flag     = (pll_state_reg == scpsel_pkg::SCPSEL_PLL_RUN);

    always_comb begin
        pll_control_next = pll_control_reg;
        if (wr_pll) begin
            pll_control_next = pwdata[7:0];
            // Unimplemented bit 6 is stored as 0 whatever software writes
            pll_control_next[scpsel_pkg::PLL_CONTROL_UNIMPL_BIT] = 1'b0;
        end
        // The stored stable bit stays 0; reads show the live flag instead
        pll_control_next[scpsel_pkg::PLL_CONTROL_STABLE_BIT] = 1'b0;
        // Internal RC gives only 12MHz, so the 6MHz reference setting is cleared
        if (!(wr_scc ? pwdata[scpsel_pkg::SCC_FAST_SEL_BIT] : fast_source_select)) begin
            pll_control_next[scpsel_pkg::PLL_CONTROL_INSEL_BIT] = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_control_reg <= scpsel_pkg::PLL_CONTROL_RESET;
        end else begin
            pll_control_reg <= pll_control_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_clock_control_reg <= scpsel_pkg::SCC_RESET;
        end else if (wr_scc) begin
            system_clock_control_reg <= {pwdata[7:5], 3'h0, pwdata[1:0]};
        end
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        case (paddr)
            scpsel_pkg::PLL_CONTROL_ADDR: begin
                rdata_next[7:0] = pll_control_reg;
                rdata_next[scpsel_pkg::PLL_CONTROL_STABLE_BIT] = pll_stable_flag;
                rdata_next[scpsel_pkg::PLL_CONTROL_UNIMPL_BIT] = 1'b0;
            end
            scpsel_pkg::SYS_CLOCK_CTRL_ADDR: begin
                rdata_next[7:0] = system_clock_control_reg;
            end
            scpsel_pkg::CLOCK_STATUS_ADDR: begin
                rdata_next[0] = pll_stable_flag;
                rdata_next[1] = fast_on_pll;
                rdata_next[2] = osc_pins_gpio;
            end
            default: begin
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdata_next;
        end
    end

    // Exactly one of two fast and one of two slow: a single bit cannot select none
    assign fast_osc_clock = fast_source_select ? ext_fast_crystal_osc : int_fast_rc_osc;
    assign slow_sub_clock = slow_source_select ? ext_slow_crystal_osc : int_slow_rc_osc;
    // Internal RC is a fixed 12MHz pin-less source
    assign osc_pins_gpio  = !fast_source_select;
    assign wdt_clk_en      = slow_sub_clock;
    assign timebase_clk_en = fast_osc_clock;

    // The reference pulse input is not used: the model derives its reference
    // from the selected fast oscillator, which is what the loop locks to
    logic ref_en;
    logic ref_half;
    // 12MHz crystal halved to 6MHz before the x8 loop; 6MHz used directly
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_half <= 1'b0;
        end else if (fast_osc_clock) begin
            ref_half <= !ref_half;
        end
    end
    assign ref_en = pll_input_select ? fast_osc_clock : (fast_osc_clock && ref_half);
    assign pll_power_on = pll_enable_bit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_state_reg <= scpsel_pkg::SCPSEL_PLL_OFF;
            lock_cnt_reg  <= '0;
        end else if (!pll_enable_bit) begin
            pll_state_reg <= scpsel_pkg::SCPSEL_PLL_OFF;
            lock_cnt_reg  <= '0;
        end else begin
            case (pll_state_reg)
                scpsel_pkg::SCPSEL_PLL_OFF: begin
                    pll_state_reg <= scpsel_pkg::SCPSEL_PLL_LOCK;
                    lock_cnt_reg  <= '0;
                end
                scpsel_pkg::SCPSEL_PLL_LOCK: begin
                    if (ref_en) begin
                        if (lock_cnt_reg + LOCK_WIDTH'(1) >= LOCK_WIDTH'(LOCK_CYCLES)) begin
                            pll_state_reg <= scpsel_pkg::SCPSEL_PLL_RUN;
                        end
                        lock_cnt_reg <= lock_cnt_reg + LOCK_WIDTH'(1);
                    end
                end
                scpsel_pkg::SCPSEL_PLL_RUN: begin
                    pll_state_reg <= scpsel_pkg::SCPSEL_PLL_RUN;
                end
                default: begin
                    pll_state_reg <= scpsel_pkg::SCPSEL_PLL_OFF;
                end
            endcase
        end
    end

    // VCO runs at 96MHz; /2 gives USB 48, /16 gives 6, /8 gives 12, /6 gives 16
    logic [4:0] pll_ratio;
    logic       usb_div_en;
    logic       pll_sys_en;
    logic       pll_pick;
    logic       pll_mux_en;
    logic       vco_en;
    assign vco_en = pll_vco_96mhz_en && pll_stable_flag;
    // A stopped PLL cannot clock the switch away from itself, so it is treated
    // as always ready to leave; the price is one last enable when it stops
    assign pll_mux_en = pll_sys_en || !pll_stable_flag;

    always_comb begin
        case (pll_output_select)
            scpsel_pkg::OSEL_6MHZ:  pll_ratio = 5'd16;
            scpsel_pkg::OSEL_12MHZ: pll_ratio = 5'd8;
            scpsel_pkg::OSEL_16MHZ: pll_ratio = 5'd6;
            // Reserved 111 gets a harmless ratio; the switch never picks it
            default:                pll_ratio = 5'd16;
        endcase
    end
    // Reserved 111 keeps the oscillator source
    assign pll_pick = pll_enable_bit && pll_output_select[2]
                   && (pll_output_select != 3'h7) && pll_stable_flag;

    // USB rate is fixed: it divides the VCO directly, never the system select
    scpsel_divider #(.WIDTH(5)) u_usb_div (
        .pclk    (pclk),
        .presetn (presetn),
        .src_en  (vco_en),
        .ratio   (5'd2),
        .div_en  (usb_div_en)
    );
    assign usb_clk_en = usb_div_en;

    scpsel_divider #(.WIDTH(5)) u_pll_div (
        .pclk    (pclk),
        .presetn (presetn),
        .src_en  (vco_en),
        .ratio   (pll_ratio),
        .div_en  (pll_sys_en)
    );

    scpsel_glitchless_mux u_fast_mux (
        .pclk    (pclk),
        .presetn (presetn),
        .sel_b   (pll_pick),
        .en_a    (fast_osc_clock),
        .en_b    (pll_mux_en),
        .en_out  (fast_clock),
        .on_b    (fast_on_pll)
    );

    // Select 0..6 divides fast clock by 64,32,16..1; 7 takes the slow clock
    logic [6:0] sys_ratio;
    logic       fast_div_en;
    always_comb begin
        case (system_clock_select)
            3'h0:    sys_ratio = 7'd64;
            3'h1:    sys_ratio = 7'd32;
            3'h2:    sys_ratio = 7'd16;
            3'h3:    sys_ratio = 7'd8;
            3'h4:    sys_ratio = 7'd4;
            3'h5:    sys_ratio = 7'd2;
            3'h6:    sys_ratio = 7'd1;
            default: sys_ratio = 7'd1;
        endcase
    end

    scpsel_divider #(.WIDTH(7)) u_sys_div (
        .pclk    (pclk),
        .presetn (presetn),
        .src_en  (fast_clock),
        .ratio   (sys_ratio),
        .div_en  (fast_div_en)
    );

    scpsel_glitchless_mux u_sys_mux (
        .pclk    (pclk),
        .presetn (presetn),
        .sel_b   (system_clock_select == scpsel_pkg::CKS_SLOW),
        .en_a    (fast_div_en),
        .en_b    (slow_sub_clock),
        .en_out  (sys_clk_en),
        .on_b    ()
    );
endmodule
`default_nettype wire

/* File: rtl/scpsel_pkg.sv */
package scpsel_pkg;
    // Register byte addresses
    localparam logic [11:0] PLL_CONTROL_ADDR     = 12'h000;
    localparam logic [11:0] SYS_CLOCK_CTRL_ADDR  = 12'h004;
    localparam logic [11:0] CLOCK_STATUS_ADDR    = 12'h008;
    // pll_control_reg fields
    localparam int PLL_CONTROL_ENABLE_BIT  = 0;
    localparam int PLL_CONTROL_STABLE_BIT  = 1;
    localparam int PLL_CONTROL_OSEL_LO     = 2;
    localparam int PLL_CONTROL_INSEL_BIT   = 5;
    localparam int PLL_CONTROL_UNIMPL_BIT  = 6;
    localparam int PLL_CONTROL_RSVD_BIT    = 7;
    localparam logic [7:0] PLL_CONTROL_RESET = 8'h01;
    // system_clock_control_reg fields
    localparam int SCC_SLOW_SEL_BIT = 0;
    localparam int SCC_FAST_SEL_BIT = 1;
    localparam int SCC_CKS_LO       = 5;
    localparam logic [7:0] SCC_RESET = 8'h00;
    // PLL output and system clock select codes
    localparam logic [2:0] OSEL_6MHZ  = 3'h6 - 3'h2;
    localparam logic [2:0] OSEL_12MHZ = 3'h5;
    localparam logic [2:0] OSEL_16MHZ = 3'h6;
    localparam logic [2:0] CKS_SLOW   = 3'h7;
    // Clock figures
    localparam int PCLK_MHZ        = 250;
    localparam int USB_CLK_MHZ     = 48;
    localparam int PLL_MUL         = 8;
    localparam int PLL_REF_DIV12   = 2;
    localparam int LOCK_REF_CYCLES = 64;
    // Clock-switch sync stages
    localparam int SW_SYNC_STAGES  = 2;
    typedef enum logic [2:0] {
        SCPSEL_PLL_OFF  = 3'b001,
        SCPSEL_PLL_LOCK = 3'b010,
        SCPSEL_PLL_RUN  = 3'b100
    } scpsel_pll_state_t;
endpackage

/* File: rtl/scpsel_divider.sv */
`timescale 1ns/1ps
`default_nettype none
// Enable-pulse divider: one pulse every ratio cycles of the source enable
module scpsel_divider #(
    parameter int WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             src_en,
    input  wire logic [WIDTH-1:0] ratio,
    output logic                  div_en
);
    logic [WIDTH-1:0] cnt_reg;
    initial begin
        if (WIDTH < 2) $error("scpsel_divider WIDTH too small");
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
        end else if (src_en) begin
            if (cnt_reg + WIDTH'(1) >= ratio) begin
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + WIDTH'(1);
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_en <= 1'b0;
        end else begin
            div_en <= src_en && (cnt_reg + WIDTH'(1) >= ratio);
        end
    end
endmodule
`default_nettype wire

/* File: rtl/scpsel_glitchless_mux.sv */
`timescale 1ns/1ps
`default_nettype none
// Break-before-make switch between two enable streams
module scpsel_glitchless_mux (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic sel_b,
    input  wire logic en_a,
    input  wire logic en_b,
    output logic      en_out,
    output logic      on_b
);
    logic a_on_reg;
    logic b_on_reg;
    // A side leaves only on its own edge; B joins only after A is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_on_reg <= 1'b1;
        end else if (en_a || !a_on_reg) begin
            a_on_reg <= !sel_b && !b_on_reg;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            b_on_reg <= 1'b0;
        end else if (en_b || !b_on_reg) begin
            b_on_reg <= sel_b && !a_on_reg;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_out <= 1'b0;
        end else begin
            en_out <= (a_on_reg && en_a) || (b_on_reg && en_b);
        end
    end
    assign on_b = b_on_reg;
endmodule
`default_nettype wire

/* File: testbench/scpsel_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module scpsel_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        ext_fast_crystal_osc,
    input wire logic        int_fast_rc_osc,
    input wire logic        ext_slow_crystal_osc,
    input wire logic        int_slow_rc_osc,
    input wire logic        pll_power_on,
    input wire logic        usb_clk_en,
    input wire logic        fast_osc_clock,
    input wire logic        slow_sub_clock,
    input wire logic        wdt_clk_en,
    input wire logic        timebase_clk_en,
    input wire logic        osc_pins_gpio
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic wr_acc = psel && penable && pwrite && pstrb[0];
    wire logic pll_hit = paddr == scpsel_pkg::PLL_CONTROL_ADDR;
    AST_RESET_EN: assert property ($rose(presetn) |-> pll_power_on)
        else $error("PLL not enabled after reset");
    AST_PLL_WRITE: assert property (wr_acc && pll_hit |=> pll_power_on == $past(pwdata[0]))
        else $error("PLL power does not follow enable write");
    AST_GPIO_WRITE: assert property (wr_acc && paddr == scpsel_pkg::SYS_CLOCK_CTRL_ADDR
        |=> osc_pins_gpio == !$past(pwdata[1]))
        else $error("Pin release does not follow fast select");
    AST_FAST_MUX: assert property (fast_osc_clock ==
        (osc_pins_gpio ? int_fast_rc_osc : ext_fast_crystal_osc))
        else $error("Fast oscillator mux wrong");
    AST_FEEDS: assert property (wdt_clk_en == slow_sub_clock &&
        timebase_clk_en == fast_osc_clock)
        else $error("Watchdog or time base feed wrong");
    AST_SLOW_MUX: assert property (ext_slow_crystal_osc == int_slow_rc_osc
        |-> slow_sub_clock == ext_slow_crystal_osc)
        else $error("Slow clock without source");
    AST_USB_OFF: assert property (!pll_power_on [*3] |-> !usb_clk_en)
        else $error("USB clock while PLL off");
    AST_USB_HALF: assert property (usb_clk_en |=> !usb_clk_en)
        else $error("USB clock not halved");
    AST_RD_BIT6: assert property (psel && penable && !pwrite && pll_hit
        |-> prdata[31:8] == 24'h00_0000 && !prdata[6])
        else $error("Unimplemented PLL bits read nonzero");
    cover property (wr_acc && pll_hit && !pwdata[0]);
    cover property (usb_clk_en);
    cover property (osc_pins_gpio ##1 !osc_pins_gpio);
endmodule
bind scpsel_top scpsel_checker scpsel_checker_inst (.*);
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [11:0] PA = scpsel_pkg::PLL_CONTROL_ADDR;
    localparam logic [11:0] SA = scpsel_pkg::SYS_CLOCK_CTRL_ADDR;
    localparam logic [11:0] TA = scpsel_pkg::CLOCK_STATUS_ADDR;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [3:0]  pstrb;
    logic        ext_fast_crystal_osc, int_fast_rc_osc, ext_slow_crystal_osc;
    logic        int_slow_rc_osc, pll_ref_6mhz_en, pll_vco_96mhz_en;
    logic        pll_power_on, usb_clk_en, fast_osc_clock, fast_clock, slow_sub_clock;
    logic        sys_clk_en, wdt_clk_en, timebase_clk_en, osc_pins_gpio;
    int          fail_count, num_checks, cyc, usb_n, sys_n, fast_n, osc_n, slow_n, d;
    scpsel_top #(.LOCK_CYCLES(4)) scpsel_top_inst (.*);
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Oscillators at different rates so a wrong mux shows in pulse counts
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        ext_fast_crystal_osc <= (cyc % 3 == 0);
        int_fast_rc_osc <= (cyc % 4 == 0);
        ext_slow_crystal_osc <= (cyc % 16 == 0);
        int_slow_rc_osc <= (cyc % 20 == 0);
        pll_ref_6mhz_en <= (cyc % 8 == 0);
        pll_vco_96mhz_en <= (cyc % 3 != 0);
        if (cyc == 40000) begin
            fail_count++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dt);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dt;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the bench timeout ends a stalled access
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdata = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_stat(input logic [31:0] m, input logic [31:0] e);
        int n;
        n = 0;
        apb(1'b0, TA, 32'h0);
        while ((rdata & m) !== e && n < 80) begin
            n++;
            apb(1'b0, TA, 32'h0);
        end
    endtask
    task automatic count(input int n);
        {usb_n, sys_n, fast_n, osc_n, slow_n} = '0;
        repeat (n) begin
            @(posedge pclk);
            usb_n += usb_clk_en;
            sys_n += sys_clk_en;
            fast_n += fast_clock;
            osc_n += fast_osc_clock;
            slow_n += slow_sub_clock;
        end
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'h1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, PA, 32'h0);
        check("pll_control_rst", rdata & 32'hFFFF_FFFD, 32'h0000_0001);
        apb(1'b0, SA, 32'h0);
        check("scc_rst", rdata, 32'h0000_0000);
        check("gpio_rst", osc_pins_gpio, 1'b1);
        wait_stat(32'h1, 32'h1);
        apb(1'b0, PA, 32'h0);
        check("pll_stable_flag_set", rdata[1], 1'b1);
        count(64);
        check("usb_on", usb_n > 0, 1'b1);
        apb(1'b1, PA, 32'h0);
        apb(1'b0, PA, 32'h0);
        check("pll_off", rdata[1:0], 2'b00);
        check("pwr_off", pll_power_on, 1'b0);
        count(64);
        check("usb_off", usb_n, 0);
        apb(1'b1, PA, 32'h1);
        apb(1'b0, PA, 32'h0);
        check("pll_stable_flag_clr", rdata[1:0], 2'b01);
        wait_stat(32'h1, 32'h1);
        check("relock", rdata[0], 1'b1);
        apb(1'b1, SA, 32'h3);
        apb(1'b1, PA, 32'h61);
        apb(1'b0, PA, 32'h0);
        check("insel_keep", rdata[6:5], 2'b01);
        check("gpio_xtal", osc_pins_gpio, 1'b0);
        count(48);
        check("xtal_fast", osc_n, 16);
        check("xtal_slow", slow_n, 3);
        apb(1'b1, SA, 32'h0);
        apb(1'b0, PA, 32'h0);
        check("insel_clr", rdata[5], 1'b0);
        check("gpio_rc", osc_pins_gpio, 1'b1);
        count(60);
        check("rc_fast", osc_n, 15);
        check("rc_slow", slow_n, 3);
        // Reserved code must keep the oscillator path
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, PA, 32'(c << 2) | 32'h1);
            wait_stat(32'h2, {30'h0, c[2] && c != 7, 1'b0});
            check("osel", rdata[1], c[2] && c != 7);
        end
        apb(1'b1, PA, 32'h11);
        wait_stat(32'h2, 32'h2);
        check("osel_on", rdata[1], 1'b1);
        apb(1'b1, PA, 32'h10);
        wait_stat(32'h2, 32'h0);
        check("osel_off", rdata[1], 1'b0);
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, SA, 32'(s << 5));
            apb(1'b0, SA, 32'h0);
            check("scc_rb", rdata, 32'(s << 5));
            count(1024);
            d = sys_n - ((s == 7) ? slow_n : fast_n / (64 >> s));
            check("div", d >= -2 && d <= 2, 1'b1);
        end
        apb(1'b0, 12'h00C, 32'h0);
        check("unmap_err", perr, 1'b1);
        check("unmap_rd", rdata, 32'h0000_0000);
        apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
        apb(1'b0, SA, 32'h0);
        check("scc_keep", rdata, 32'h0000_00E0);
        summarize();
    end
endmodule
`default_nettype wire
